// *** design/hbi_pkg.sv ***
// Functional notes
// - hardware mode: pin is template bit one
// - hardware mode: pin is template bit zero
// - intel read only while read strobe low
// - motorola direction pin low write, high read
// - serial input sampled on rising shift clock
// - intel write data captured on strobe rise
// - motorola data strobe qualifies, read drives bus
// - serial write keeps serial output floating
// - serial read floats output during command byte
// - edge select picks serial output shift edge
// - intel ready high completes, low inserts waits
// - motorola acknowledge low when read data valid
// - motorola acknowledge low when write accepted
// - open drain interrupt low when source pending
// - non-muxed pins are data, driven on reads
// - muxed pins carry address then data
// - intel muxed address latched on latch fall
// - motorola muxed address latched on strobe fall
package hbi_pkg;
  // ============================================================
  // modes
  typedef enum logic [2:0] {
    HBI_HW = 3'h0,
    HBI_SERIAL = 3'h1,
    HBI_INTEL_NMX = 3'h2,
    HBI_INTEL_MX = 3'h3,
    HBI_MOTO_NMX = 3'h4,
    HBI_MOTO_MX = 3'h5
  } hbi_mode_e;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'hF;
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_ADDR_LSB = 0;
  // ============================================================
  // register access request toward the core
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbi_req_s;
  // synchronised pin set
  typedef struct packed {
    logic csN;
    logic aleAs;
    logic rdRw;
    logic wrDs;
    logic serial_in;
    logic sclk;
    logic edge_select;
    logic [DATA_W-1:0] bus;
  } hbi_pins_s;
endpackage : hbi_pkg

// *** design/hbi_host_bus.sv ***
`timescale 1ns/10ps
module hbi_host_bus (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic nrst, // synchronous reset, active low
  input wire hbi_pkg::hbi_mode_e mode, // host interface mode strap
  input wire logic csN, // chip select, active low
  input wire logic aleAs, // latch enable / address strobe pin
  input wire logic rdRw, // read strobe / direction / template bit 1
  input wire logic wrDs, // write strobe / data strobe / template bit 0
  input wire logic sclk, // serial shift clock pin
  input wire logic serial_in, // serial_in pin
  input wire logic edge_select, // edge_select pin
  input wire logic [hbi_pkg::ADDR_W-1:0] addrIn, // non-muxed address pins
  input wire logic [hbi_pkg::DATA_W-1:0] busIn, // data pins, input side
  output logic [hbi_pkg::DATA_W-1:0] busOut, // data pins, output side
  output logic busOeN, // data pin enable, low drives
  output logic sdoOut, // serial_out / ready / ack value
  output logic sdoOeN, // serial_out enable, low drives
  output logic irqOut, // irq_out level, always low when driven
  output logic irqOeN, // irq_out enable, low drives
  output logic [1:0] shapeSel, // template bits one and zero
  output hbi_pkg::hbi_req_s req, // access toward register core
  input wire logic [hbi_pkg::DATA_W-1:0] rdata, // read data from core
  input wire logic [1:0] irqSrc // two interrupt sources
);
  // ============================================================
  // state
  typedef struct packed {
    hbi_pkg::hbi_pins_s s1;
    hbi_pkg::hbi_pins_s s2;
    hbi_pkg::hbi_pins_s s3;
    logic [hbi_pkg::ADDR_W-1:0] addrS1;
    logic [hbi_pkg::ADDR_W-1:0] addrS2;
    logic [hbi_pkg::ADDR_W-1:0] addr;
    logic [hbi_pkg::DATA_W-1:0] shIn;
    logic [hbi_pkg::DATA_W-1:0] shOut;
    logic [hbi_pkg::BIT_CNT_W-1:0] bitCnt;
    logic serRead;
    logic serDrive;
    logic rdAct;
    logic [hbi_pkg::DATA_W-1:0] busOut;
    logic serial_out;
    logic [1:0] shape;
    hbi_pkg::hbi_req_s req;
    logic irq;
  } hbi_state_s;

  hbi_state_s st_r;
  hbi_state_s st_nxt;
  hbi_pkg::hbi_pins_s pinsNow;

  function automatic logic isMux(input hbi_pkg::hbi_mode_e m);
    return (m == hbi_pkg::HBI_INTEL_MX) || (m == hbi_pkg::HBI_MOTO_MX);
  endfunction : isMux

  function automatic logic isMoto(input hbi_pkg::hbi_mode_e m);
    return (m == hbi_pkg::HBI_MOTO_NMX) || (m == hbi_pkg::HBI_MOTO_MX);
  endfunction : isMoto

  function automatic logic isIntel(input hbi_pkg::hbi_mode_e m);
    return (m == hbi_pkg::HBI_INTEL_NMX) || (m == hbi_pkg::HBI_INTEL_MX);
  endfunction : isIntel

  logic sclkRise;
  logic sclkFall;
  logic sdoEdge;
  logic rdStrobe;
  logic wrStrobe;
  logic rdFall;
  logic wrRise;
  logic latchFall;
  logic csAct;
  logic [hbi_pkg::DATA_W-1:0] cmdByte;

  always_comb begin
    pinsNow.csN = csN;
    pinsNow.aleAs = aleAs;
    pinsNow.rdRw = rdRw;
    pinsNow.wrDs = wrDs;
    pinsNow.serial_in = serial_in;
    pinsNow.sclk = sclk;
    pinsNow.edge_select = edge_select;
    pinsNow.bus = busIn;
  end

  // ============================================================
  // edge detection on second and third stages only
  always_comb begin
    csAct = !st_r.s2.csN;
    // command byte as it stands once its last bit arrives
    cmdByte = {st_r.shIn[hbi_pkg::DATA_W-2:0], st_r.s2.serial_in};
    sclkRise = st_r.s2.sclk && !st_r.s3.sclk;
    sclkFall = !st_r.s2.sclk && st_r.s3.sclk;
    sdoEdge = st_r.s2.edge_select ? sclkFall : sclkRise;
    if (isMoto(mode)) begin
      rdStrobe = csAct && !st_r.s2.wrDs && st_r.s2.rdRw;
      wrStrobe = csAct && !st_r.s2.wrDs && !st_r.s2.rdRw;
      rdFall = rdStrobe && !(!st_r.s3.wrDs && st_r.s3.rdRw && !st_r.s3.csN);
      wrRise = !csAct || st_r.s2.wrDs ? (!st_r.s3.csN && !st_r.s3.wrDs && !st_r.s3.rdRw) : 1'b0;
    end else begin
      rdStrobe = csAct && !st_r.s2.rdRw;
      wrStrobe = csAct && !st_r.s2.wrDs;
      rdFall = rdStrobe && (st_r.s3.rdRw || st_r.s3.csN);
      wrRise = (st_r.s2.wrDs || !csAct) && !st_r.s3.wrDs && !st_r.s3.csN;
    end
    latchFall = !st_r.s2.aleAs && st_r.s3.aleAs;
  end

  // ============================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinsNow;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.addrS1 = addrIn;
    st_nxt.addrS2 = st_r.addrS1;
    st_nxt.req.wrStb = 1'b0;
    st_nxt.req.rdStb = 1'b0;
    st_nxt.irq = |irqSrc;
    st_nxt.shape = 2'h0;
    case (mode)
      hbi_pkg::HBI_HW: begin
        st_nxt.shape = {st_r.s2.rdRw, st_r.s2.wrDs};
        st_nxt.rdAct = 1'b0;
        st_nxt.serDrive = 1'b0;
      end
      hbi_pkg::HBI_SERIAL: begin
        st_nxt.rdAct = 1'b0;
        if (!csAct) begin
          st_nxt.bitCnt = '0;
          st_nxt.serDrive = 1'b0;
          st_nxt.serRead = 1'b0;
        end else begin
          if (sclkRise) begin
            st_nxt.shIn = {st_r.shIn[hbi_pkg::DATA_W-2:0], st_r.s2.serial_in};
            st_nxt.bitCnt = (st_r.bitCnt == hbi_pkg::FRAME_BITS) ? st_r.bitCnt : st_r.bitCnt + 4'h1;
            if (st_r.bitCnt == hbi_pkg::CMD_BITS - 4'h1) begin
              st_nxt.serRead = cmdByte[hbi_pkg::CMD_RW_BIT];
              st_nxt.addr = cmdByte[hbi_pkg::CMD_ADDR_LSB +: hbi_pkg::ADDR_W];
              st_nxt.req.addr = cmdByte[hbi_pkg::CMD_ADDR_LSB +: hbi_pkg::ADDR_W];
              if (cmdByte[hbi_pkg::CMD_RW_BIT]) begin
                st_nxt.req.rdStb = 1'b1;
              end
            end
            if (st_r.bitCnt == hbi_pkg::FRAME_BITS && !st_r.serRead) begin
              st_nxt.req.wdata = {st_r.shIn[hbi_pkg::DATA_W-2:0], st_r.s2.serial_in};
              st_nxt.req.addr = st_r.addr;
              st_nxt.req.wrStb = 1'b1;
            end
          end
          // drive only in read data phase
          if (st_r.serRead && st_r.bitCnt >= hbi_pkg::CMD_BITS) begin
            st_nxt.serDrive = 1'b1;
          end
          if (st_r.req.rdStb) begin
            st_nxt.shOut = rdata;
          end else if (sdoEdge && st_r.serDrive) begin
            st_nxt.serial_out = st_r.shOut[hbi_pkg::DATA_W-1];
            st_nxt.shOut = {st_r.shOut[hbi_pkg::DATA_W-2:0], 1'b0};
          end else if (st_r.serRead && !st_r.serDrive && st_r.bitCnt >= hbi_pkg::CMD_BITS) begin
            st_nxt.serial_out = st_r.shOut[hbi_pkg::DATA_W-1];
            st_nxt.shOut = {st_r.shOut[hbi_pkg::DATA_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        st_nxt.serDrive = 1'b0;
        if (isMux(mode) && latchFall && csAct) begin
          st_nxt.addr = st_r.s2.bus[hbi_pkg::ADDR_W-1:0];
        end else if (!isMux(mode)) begin
          st_nxt.addr = st_r.addrS2;
        end
        if (rdFall) begin
          st_nxt.req.addr = isMux(mode) ? st_r.addr : st_r.addrS2;
          st_nxt.req.rdStb = 1'b1;
        end
        if (st_r.req.rdStb) begin
          st_nxt.busOut = rdata;
          st_nxt.rdAct = 1'b1;
        end
        if (!rdStrobe) begin
          st_nxt.rdAct = 1'b0;
        end
        if (wrRise) begin
          st_nxt.req.wdata = st_r.s3.bus;
          st_nxt.req.addr = isMux(mode) ? st_r.addr : st_r.addrS2;
          st_nxt.req.wrStb = 1'b1;
        end
        if (isIntel(mode)) begin
          st_nxt.serial_out = !(rdStrobe && !st_r.rdAct);
        end else begin
          st_nxt.serial_out = !((rdStrobe && st_r.rdAct) || (wrStrobe && st_r.s3.wrDs == 1'b0 && !st_r.s3.csN));
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.s3 <= '1;
      // shift clock idles low, so no false edge after reset
      st_r.s1.sclk <= 1'b0;
      st_r.s2.sclk <= 1'b0;
      st_r.s3.sclk <= 1'b0;
      st_r.serial_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // outputs
  always_comb begin
    busOut = st_r.busOut;
    busOeN = !(st_r.rdAct && rdStrobe);
    sdoOut = st_r.serial_out;
    if (mode == hbi_pkg::HBI_SERIAL) begin
      sdoOeN = !(st_r.serDrive && csAct);
    end else if (mode == hbi_pkg::HBI_HW) begin
      sdoOeN = 1'b1;
    end else begin
      sdoOeN = !csAct;
    end
    irqOut = 1'b0;
    irqOeN = !st_r.irq;
    shapeSel = st_r.shape;
    req = st_r.req;
  end

  // ============================================================
  // checks
  // bus release
  a_bus_release: assert property (@(posedge clk_sys) disable iff (!nrst) !rdStrobe |-> busOeN)
    else $error("bus driven outside read");
  a_ser_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_SERIAL && !st_r.serRead) |-> sdoOeN)
    else $error("serial output driven in write");
  a_irq_drive: assert property (@(posedge clk_sys) disable iff (!nrst) (|irqSrc) |=> !irqOeN)
    else $error("interrupt not asserted");
  a_shape_bit1: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_HW) |=> shapeSel[1] == $past(st_r.s2.rdRw))
    else $error("template bit one wrong");
  a_shape_bit0: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_HW) |=> shapeSel[0] == $past(st_r.s2.wrDs))
    else $error("template bit zero wrong");
  a_write_cap: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isIntel(mode) && wrRise) |=> req.wrStb && req.wdata == $past(st_r.s3.bus))
    else $error("write data not captured");
  a_read_req: assert property (@(posedge clk_sys) disable iff (!nrst) req.rdStb |-> $past(csN, 3) == 1'b0 || mode == hbi_pkg::HBI_SERIAL)
    else $error("read without select");
  a_ready_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isIntel(mode) && rdFall) |=> !sdoOut ##[1:3] sdoOut)
    else $error("ready not released");

  a_ser_sample: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_SERIAL && csAct && sclkRise) |=> st_r.shIn[0] == $past(st_r.s2.serial_in))
    else $error("serial input not sampled");

  a_ser_cmd: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_SERIAL && csAct && sclkRise && st_r.bitCnt == hbi_pkg::CMD_BITS - 4'h1)
    |=> st_r.serRead == $past(cmdByte[hbi_pkg::CMD_RW_BIT]))
    else $error("serial direction not decoded");

  a_ser_cmd_float: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_SERIAL && st_r.bitCnt < hbi_pkg::CMD_BITS) |-> sdoOeN)
    else $error("serial output driven in command");

  a_ser_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_SERIAL && csAct && sdoEdge && st_r.serDrive && !req.rdStb)
    |=> sdoOut == $past(st_r.shOut[hbi_pkg::DATA_W-1]))
    else $error("serial output not shifted");

  a_intel_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isIntel(mode) && rdStrobe && !st_r.rdAct) |=> !sdoOut)
    else $error("ready high before data");

  a_moto_rd_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isMoto(mode) && rdStrobe && st_r.rdAct) |=> !sdoOut)
    else $error("read not acknowledged");

  a_moto_wr_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isMoto(mode) && wrStrobe && !st_r.s3.wrDs && !st_r.s3.csN) |=> !sdoOut)
    else $error("write not acknowledged");

  a_moto_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isMoto(mode) && rdFall) |=> req.rdStb && !req.wrStb)
    else $error("direction not decoded");

  a_read_data: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((isIntel(mode) || isMoto(mode)) && req.rdStb) |=> busOut == $past(rdata))
    else $error("read data not loaded");

  a_read_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((isIntel(mode) || isMoto(mode)) && rdStrobe && st_r.rdAct) |-> !busOeN)
    else $error("bus not driven in read");

  a_nmx_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((isIntel(mode) || isMoto(mode)) && !isMux(mode)) |=> st_r.addr == $past(st_r.addrS2))
    else $error("address pins not followed");

  a_mux_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (isMux(mode) && latchFall && csAct) |=> st_r.addr == $past(st_r.s2.bus[hbi_pkg::ADDR_W-1:0]))
    else $error("address not latched");

  a_irq_release: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(|irqSrc) |=> irqOeN && !irqOut)
    else $error("interrupt not released");

  a_hw_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == hbi_pkg::HBI_HW) |-> sdoOeN && busOeN)
    else $error("pins driven in hardware mode");

  a_write_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.wrStb |=> !req.wrStb)
    else $error("write pulse too long");
endmodule : hbi_host_bus

// *** test/hbi_host_model.sv ***
`timescale 1ns/10ps
module hbi_host_model (
  input wire logic clk_sys, // system clock
  output logic csN, // chip select
  output logic aleAs, // latch enable or address strobe
  output logic rdRw, // read strobe or direction
  output logic wrDs, // write strobe or data strobe
  output logic sclk, // shift clock, low outside frames
  output logic serial_in, // serial data toward device
  output logic [7:0] hBus, // host side bus value
  output logic hOeN, // host bus enable, low drives
  input wire logic [7:0] bus, // resolved bus
  input wire logic serial_out, // serial_out, ready or ack
  input wire logic sdoOeN, // serial_out enable
  input wire logic devOeN, // device bus enable
  input wire logic edge_select // edge select
);
  initial begin
    {csN, aleAs, rdRw, wrDs, sclk, serial_in, hOeN} = 7'h79;
    hBus = 8'h00;
  end
  task automatic strap(input logic [1:0] v);
    {rdRw, wrDs} = v;
  endtask : strap
  // ============================================================
  // parallel cycle
  task automatic par(input logic moto, mx, rd, input logic [7:0] a, d, output logic [7:0] rx, output logic ok);
    @(negedge clk_sys);
    csN = 1'b0;
    if (mx) begin
      hBus = a;
      hOeN = 1'b0;
      aleAs = 1'b0;
      repeat (6) @(negedge clk_sys);
      aleAs = 1'b1;
    end
    hBus = d;
    hOeN = rd;
    rdRw = moto ? rd : !rd;
    wrDs = moto ? 1'b0 : rd;
    repeat (4) @(posedge clk_sys);
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(negedge clk_sys);
      ok = (serial_out === !moto) && (!rd || devOeN === 1'b0);
    end
    rx = bus;
    @(negedge clk_sys);
    {csN, rdRw, wrDs, hOeN} = 4'hF;
    repeat (4) @(negedge clk_sys);
  endtask : par
  // ============================================================
  // serial frame
  // command byte then data byte
  task automatic ser(input logic rd, input logic [7:0] a, d, output logic [7:0] rx, output logic ok);
    logic [15:0] f;
    f = {1'b0, rd, 1'b0, a[4:0], d};
    ok = 1'b1;
    rx = 8'h00;
    csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in = f[i];
      repeat (4) @(negedge clk_sys);
      if (i < 8 && edge_select)
        rx[i] = serial_out;
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      if (i < 8 && !edge_select)
        rx[i] = serial_out;
      if ((i > 8 || !rd) && sdoOeN !== 1'b1)
        ok = 1'b0;
      if (rd && i < 8 && sdoOeN !== 1'b0)
        ok = 1'b0;
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    csN = 1'b1;
  endtask : ser
endmodule : hbi_host_model

// *** test/host_bus_interface_tb.sv ***
`timescale 1ns/10ps
module host_bus_interface_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  hbi_pkg::hbi_mode_e mode = hbi_pkg::HBI_HW;
  logic csN, aleAs, rdRw, wrDs, sclk, serial_in, hOeN, busOeN, sdoOut, sdoOeN, irqOut, irqOeN, ok;
  logic edge_select = 1'b0;
  logic [1:0] irqSrc = 2'h0;
  logic [1:0] shapeSel;
  logic [4:0] addrIn = 5'h00;
  logic [4:0] wA;
  logic [7:0] hBus, busIn, busOut, rx, a, d, wD;
  logic [7:0] rdata = 8'h00;
  logic [7:0] noise = 8'h5A;
  hbi_pkg::hbi_req_s req;
  int fails = 0;
  int checked = 0;
  int wrN = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) noise <= ~noise;
  assign busIn = !busOeN ? busOut : (!hOeN ? hBus : noise);
  always @(posedge clk_sys) begin
    if (req.wrStb === 1'b1) begin
      wrN <= wrN + 1;
      wA <= req.addr;
      wD <= req.wdata;
    end
  end
  hbi_host_model u_host (.clk_sys(clk_sys), .csN(csN), .aleAs(aleAs), .rdRw(rdRw), .wrDs(wrDs), .sclk(sclk),
    .serial_in(serial_in), .hBus(hBus), .hOeN(hOeN), .bus(busIn), .serial_out(sdoOut), .sdoOeN(sdoOeN), .devOeN(busOeN), .edge_select(edge_select));
  hbi_host_bus u_dut (.clk_sys(clk_sys), .nrst(nrst), .mode(mode), .csN(csN), .aleAs(aleAs), .rdRw(rdRw),
    .wrDs(wrDs), .sclk(sclk), .serial_in(serial_in), .edge_select(edge_select), .addrIn(addrIn), .busIn(busIn), .busOut(busOut),
    .busOeN(busOeN), .sdoOut(sdoOut), .sdoOeN(sdoOeN), .irqOut(irqOut), .irqOeN(irqOeN), .shapeSel(shapeSel),
    .req(req), .rdata(rdata), .irqSrc(irqSrc));
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic restart(input hbi_pkg::hbi_mode_e m);
    @(negedge clk_sys);
    nrst = 1'b0;
    mode = m;
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : restart
  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
  // ============================================================
  // tests
  initial begin
    void'($urandom(32'hC003));
    restart(hbi_pkg::HBI_HW);
    for (int i = 0; i < 8; i++) begin
      u_host.strap(2'($urandom));
      irqSrc = 2'($urandom);
      @(negedge clk_sys);
      chk({6'h00, irqOut, irqOeN}, {7'h00, ~|irqSrc});
      repeat (5) @(negedge clk_sys);
      chk({6'h00, shapeSel}, {6'h00, rdRw, wrDs});
    end
    for (int m = 2; m < 6; m++) begin
      restart(hbi_pkg::hbi_mode_e'(m));
      for (int i = 0; i < 6; i++) begin
        a = 8'($urandom);
        d = 8'($urandom);
        rdata = 8'($urandom);
        addrIn = m[0] ? ~a[4:0] : a[4:0];
        n = wrN;
        u_host.par(m > 3, m[0], i[0], a, d, rx, ok);
        repeat (6) @(negedge clk_sys);
        chk({7'h00, ok}, 8'h01);
        chk({7'h00, busOeN}, 8'h01);
        chk(8'(wrN - n), {7'h00, !i[0]});
        if (i[0])
          chk(rx, rdata);
        else
          chk({wD[7:5], wA}, {d[7:5], a[4:0]});
        if (!i[0])
          chk(wD, d);
      end
    end
    restart(hbi_pkg::HBI_SERIAL);
    for (int i = 0; i < 4; i++) begin
      edge_select = i[1];
      a = 8'($urandom);
      d = 8'($urandom);
      rdata = 8'($urandom);
      n = wrN;
      u_host.ser(i[0], a, d, rx, ok);
      repeat (6) @(negedge clk_sys);
      chk({7'h00, ok}, 8'h01);
      chk(8'(wrN - n), {7'h00, !i[0]});
      if (i[0])
        chk(rx, rdata);
      else
        chk({wD[7:5], wA}, {d[7:5], a[4:0]});
    end
    give_verdict();
  end
endmodule : host_bus_interface_tb
